// [src/tpw_pkg.sv]
package tpw_pkg;

  localparam logic [2:0] ADDR_CTRL  = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_CMPA  = 3'h2;
  localparam logic [2:0] ADDR_CMPB  = 3'h3;
  localparam logic [2:0] ADDR_CAPT  = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;

  localparam int FLAG_OVF  = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAPT = 3;

  localparam logic [3:0] MODE_NORMAL   = 4'h0;
  localparam logic [3:0] MODE_CTC_OCR  = 4'h4;
  localparam logic [3:0] MODE_FPWM8    = 4'h5;
  localparam logic [3:0] MODE_FPWM9    = 4'h6;
  localparam logic [3:0] MODE_FPWM10   = 4'h7;
  localparam logic [3:0] MODE_CTC_ICR  = 4'hC;
  localparam logic [3:0] MODE_FPWM_ICR = 4'hE;
  localparam logic [3:0] MODE_FPWM_OCR = 4'hF;

  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;

  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  typedef struct packed {
    logic [1:0] dir;     // [9:8] pin direction, 1 = output
    logic [1:0] com_b;   // [7:6]
    logic [1:0] com_a;   // [5:4]
    logic [3:0] mode;    // [3:0] waveform_mode_select
  } tpw_ctrl_type;

  localparam tpw_ctrl_type CTRL_RESET = '0;

  typedef struct packed {
    tpw_ctrl_type      ctrl;
    logic [15:0]       cnt;
    logic [1:0][15:0]  ocr_act;
    logic [1:0][15:0]  ocr_buf;
    logic [15:0]       icr;
    logic [3:0]        flags;
    logic              block;
    logic [1:0]        wave;
    logic [1:0]        pin;
    logic [1:0]        oe_n;
    logic [15:0]       rdata;
  } tpw_state_type;

  localparam tpw_state_type STATE_RESET = '{
    ctrl: CTRL_RESET, cnt: 16'h0000, ocr_act: '0, ocr_buf: '0,
    icr: 16'h0000, flags: 4'h0, block: 1'b0, wave: 2'h0,
    pin: 2'h0, oe_n: 2'h3, rdata: 16'h0000};

endpackage

// [src/tpw_timer.sv]
// Function
// - Mode 0 only counts up, wrapping
// - Normal mode: overflow flag set at MAX
// - Overflow service acknowledge clears overflow flag
// - Count writes accepted anytime, counting continues
// - Modes 4/12 clear counter at TOP
// - Unbuffered TOP below count wraps first
// - TOP register's flag set at TOP
// - Clear-on-match toggle inverts wave A
// - Pin driven only when direction is output
// - Clear-on-match still flags overflow at MAX
// - Fast PWM clears after TOP; fixed TOPs
// - Modes 14/15 take TOP from registers
// - PWM non-inverting and inverting output actions
// - PWM overflow and TOP flag at TOP
// - Compare flag set on count equal
// - Fixed-TOP modes mask written compare bits
// - PWM compare writes buffered, loaded at TOP
// - Capture TOP unbuffered, may miss TOP
// - Zero compare spikes; TOP compare constant
// - PWM toggle on channel A
// - Output mode zero leaves wave untouched
// - Count write blocks next tick's matches
`timescale 1ns/1ps
module tpw_timer (
  input  wire logic        clk_sys_in,    // 50 MHz system clock
  input  wire logic        rst_in,        // Async reset, active high
  input  wire logic        ce_in,         // Clock enable, freezes all
  input  wire logic        tick_in,       // Timer clock enable
  input  wire logic        ovf_ack_in,    // Overflow service pulse
  input  wire logic [2:0]  addr_in,       // Register index
  input  wire logic [15:0] wdata_in,      // Write data
  input  wire logic        wr_in,         // Write strobe
  input  wire logic        rd_in,         // Read strobe
  output logic      [15:0] rdata_out,     // Read data, next cycle
  output logic      [1:0]  wave_pin_out,  // Waveform pin level
  output logic      [1:0]  wave_oe_n_out  // Pin enable, low drives
);

  tpw_pkg::tpw_state_type s_r;
  tpw_pkg::tpw_state_type s_nxt;

  logic [15:0] top;
  logic        pwm;
  logic        clear_on_match_mode;
  logic        fixed_top;
  logic        top_icr;
  logic        top_ocr;
  logic        top_hit;
  logic        ovf_set;
  logic        wr_cnt;
  logic [1:0]  cmp_hit;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic [15:0] cmp_wval;
  logic [1:0]  com;

  // TOP selection per mode
  always_comb begin
    top       = tpw_pkg::CNT_MAX;
    pwm       = 1'b0;
    clear_on_match_mode       = 1'b0;
    fixed_top = 1'b0;
    top_icr   = 1'b0;
    top_ocr   = 1'b0;
    case (s_r.ctrl.mode)
      tpw_pkg::MODE_CTC_OCR: begin
        clear_on_match_mode     = 1'b1;
        top     = s_r.ocr_act[0];
        top_ocr = 1'b1;
      end
      tpw_pkg::MODE_CTC_ICR: begin
        clear_on_match_mode     = 1'b1;
        top     = s_r.icr;
        top_icr = 1'b1;
      end
      tpw_pkg::MODE_FPWM8: begin
        pwm       = 1'b1;
        fixed_top = 1'b1;
        top       = tpw_pkg::TOP_8BIT;
      end
      tpw_pkg::MODE_FPWM9: begin
        pwm       = 1'b1;
        fixed_top = 1'b1;
        top       = tpw_pkg::TOP_9BIT;
      end
      tpw_pkg::MODE_FPWM10: begin
        pwm       = 1'b1;
        fixed_top = 1'b1;
        top       = tpw_pkg::TOP_10BIT;
      end
      tpw_pkg::MODE_FPWM_ICR: begin
        pwm     = 1'b1;
        top     = s_r.icr;
        top_icr = 1'b1;
      end
      tpw_pkg::MODE_FPWM_OCR: begin
        pwm     = 1'b1;
        top     = s_r.ocr_act[0];
        top_ocr = 1'b1;
      end
      default: begin
      end
    endcase
  end

  assign wr_cnt = wr_in && (addr_in == tpw_pkg::ADDR_COUNT);

  // Equality only, so a TOP below the count is passed by
  assign top_hit = tick_in && (clear_on_match_mode || pwm) && (s_r.cnt == top)
                   && (fixed_top || !s_r.block);

  assign ovf_set = tick_in && (pwm ? top_hit
                               : (s_r.cnt == tpw_pkg::CNT_MAX));

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cmp
      assign cmp_hit[g] = tick_in && !s_r.block
                          && (s_r.cnt == s_r.ocr_act[g]);
    end
  endgenerate

  always_comb begin
    flag_set                     = 4'h0;
    flag_set[tpw_pkg::FLAG_OVF]  = ovf_set;
    flag_set[tpw_pkg::FLAG_CMPA] = cmp_hit[0] || (top_hit && top_ocr);
    flag_set[tpw_pkg::FLAG_CMPB] = cmp_hit[1];
    flag_set[tpw_pkg::FLAG_CAPT] = top_hit && top_icr;
    flag_clr = (wr_in && addr_in == tpw_pkg::ADDR_FLAGS) ? wdata_in[3:0]
                                                         : 4'h0;
    flag_clr[tpw_pkg::FLAG_OVF] = flag_clr[tpw_pkg::FLAG_OVF] || ovf_ack_in;
  end

  assign cmp_wval = fixed_top ? (wdata_in & top) : wdata_in;

  always_comb begin
    s_nxt = s_r;
    com   = 2'h0;
    // Counter; the software write wins over the tick
    if (tick_in) begin
      s_nxt.block = 1'b0;
      s_nxt.cnt   = top_hit ? tpw_pkg::CNT_ZERO
                            : 16'(s_r.cnt + 16'h0001);
    end
    if (wr_cnt) begin
      s_nxt.cnt   = wdata_in;
      s_nxt.block = 1'b1;
    end
    // Set wins over clear
    s_nxt.flags = (s_r.flags & ~flag_clr) | flag_set;
    // Double buffer reload at TOP
    if (pwm && top_hit) begin
      s_nxt.ocr_act = s_r.ocr_buf;
    end
    if (wr_in && addr_in == tpw_pkg::ADDR_CTRL) begin
      s_nxt.ctrl = tpw_pkg::tpw_ctrl_type'(wdata_in[9:0]);
    end
    if (wr_in && addr_in == tpw_pkg::ADDR_CAPT) begin
      s_nxt.icr = wdata_in;
    end
    for (int ch = 0; ch < 2; ch++) begin
      if (wr_in && addr_in == (ch == 0 ? tpw_pkg::ADDR_CMPA
                                       : tpw_pkg::ADDR_CMPB)) begin
        s_nxt.ocr_buf[ch] = cmp_wval;
        if (!pwm) begin
          s_nxt.ocr_act[ch] = cmp_wval;
        end
      end
      com = (ch == 0) ? s_r.ctrl.com_a : s_r.ctrl.com_b;
      if (cmp_hit[ch]) begin
        case (com)
          tpw_pkg::COM_TOGGLE: begin
            if (ch == 0 || !pwm) begin
              s_nxt.wave[ch] = !s_r.wave[ch];
            end
          end
          tpw_pkg::COM_CLEAR: s_nxt.wave[ch] = 1'b0;
          tpw_pkg::COM_SET:   s_nxt.wave[ch] = 1'b1;
          default: begin
          end
        endcase
      end
      // BOTTOM action overrides a match at TOP
      if (pwm && top_hit && com[1]) begin
        s_nxt.wave[ch] = !com[0];
      end
      s_nxt.pin[ch]  = s_nxt.wave[ch];
      s_nxt.oe_n[ch] = !s_r.ctrl.dir[ch];
    end
    s_nxt.rdata = 16'h0000;
    if (rd_in) begin
      case (addr_in)
        tpw_pkg::ADDR_CTRL:  s_nxt.rdata = {6'h00, s_r.ctrl};
        tpw_pkg::ADDR_COUNT: s_nxt.rdata = s_r.cnt;
        tpw_pkg::ADDR_CMPA:  s_nxt.rdata = s_r.ocr_buf[0];
        tpw_pkg::ADDR_CMPB:  s_nxt.rdata = s_r.ocr_buf[1];
        tpw_pkg::ADDR_CAPT:  s_nxt.rdata = s_r.icr;
        tpw_pkg::ADDR_FLAGS: s_nxt.rdata = {12'h000, s_r.flags};
        default:             s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= tpw_pkg::STATE_RESET;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out     = s_r.rdata;
  assign wave_pin_out  = s_r.pin;
  assign wave_oe_n_out = s_r.oe_n;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_wrap;
    ce_in && tick_in && !wr_cnt && s_r.ctrl.mode == tpw_pkg::MODE_NORMAL
      && s_r.cnt == tpw_pkg::CNT_MAX |=> s_r.cnt == tpw_pkg::CNT_ZERO
      && s_r.flags[tpw_pkg::FLAG_OVF];
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to zero");

  property p_ovf_sticky;
    ce_in && s_r.flags[tpw_pkg::FLAG_OVF] && !ovf_ack_in
      && !(wr_in && addr_in == tpw_pkg::ADDR_FLAGS)
      |=> s_r.flags[tpw_pkg::FLAG_OVF];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("ovf lost");

  property p_ovf_ack;
    ce_in && ovf_ack_in && !ovf_set |=> !s_r.flags[tpw_pkg::FLAG_OVF];
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) else $error("ovf not cleared");

  property p_cnt_wr;
    ce_in && wr_cnt |=> s_r.cnt == $past(wdata_in) && s_r.block;
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");

  property p_top_clear;
    ce_in && top_hit && !wr_cnt |=> s_r.cnt == tpw_pkg::CNT_ZERO;
  endproperty
  a_top_clear: assert property (p_top_clear) else $error("no TOP clear");

  property p_cmp_flag;
    ce_in && cmp_hit[1] |=> s_r.flags[tpw_pkg::FLAG_CMPB];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("cmp flag missed");

  property p_block;
    ce_in && wr_cnt ##1 ce_in && tick_in |-> cmp_hit == 2'h0;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");

  property p_reload;
    ce_in && pwm && top_hit |=> s_r.ocr_act == $past(s_r.ocr_buf);
  endproperty
  a_reload: assert property (p_reload) else $error("buffer not loaded");

  property p_pwm_bottom;
    ce_in && pwm && top_hit && s_r.ctrl.com_a == tpw_pkg::COM_CLEAR
      |=> s_r.wave[0] && s_r.pin[0];
  endproperty
  a_pwm_bottom: assert property (p_pwm_bottom) else $error("no set at BOTTOM");

  property p_pin_dir;
    ce_in ##1 1'b1 |-> s_r.oe_n[0] == !$past(s_r.ctrl.dir[0]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin enable wrong");

  property p_hold;
    !ce_in |=> s_r == $past(s_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("state moved while held");

  property p_ctc_miss;
    ce_in && tick_in && clear_on_match_mode && !wr_cnt && s_r.cnt > top
      |=> s_r.cnt == 16'($past(s_r.cnt) + 16'h0001);
  endproperty
  a_ctc_miss: assert property (p_ctc_miss)
    else $error("TOP below count not passed by");

  property p_top_flag;
    ce_in && top_hit && top_icr |=> s_r.flags[tpw_pkg::FLAG_CAPT];
  endproperty
  a_top_flag: assert property (p_top_flag)
    else $error("capture flag missed at TOP");

  property p_ctc_toggle;
    ce_in && clear_on_match_mode && cmp_hit[0] && s_r.ctrl.com_a == tpw_pkg::COM_TOGGLE
      |=> s_r.wave[0] != $past(s_r.wave[0]);
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle)
    else $error("wave A not toggled");

  property p_ctc_ovf;
    ce_in && tick_in && clear_on_match_mode && s_r.cnt == tpw_pkg::CNT_MAX
      |=> s_r.flags[tpw_pkg::FLAG_OVF];
  endproperty
  a_ctc_ovf: assert property (p_ctc_ovf)
    else $error("overflow missed at MAX");

  property p_fixed_top;
    ce_in && tick_in && fixed_top && !wr_cnt && s_r.cnt == top
      |=> s_r.cnt == tpw_pkg::CNT_ZERO;
  endproperty
  a_fixed_top: assert property (p_fixed_top)
    else $error("fixed TOP not cleared");

  property p_pwm_ovf;
    ce_in && pwm && top_hit |=> s_r.flags[tpw_pkg::FLAG_OVF];
  endproperty
  a_pwm_ovf: assert property (p_pwm_ovf)
    else $error("overflow missed at TOP");

  property p_mask;
    ce_in && fixed_top && wr_in && addr_in == tpw_pkg::ADDR_CMPA
      |=> (s_r.ocr_buf[0] & ~$past(top)) == tpw_pkg::CNT_ZERO;
  endproperty
  a_mask: assert property (p_mask)
    else $error("compare bits above TOP kept");

  property p_pwm_toggle;
    ce_in && pwm && cmp_hit[0] && s_r.ctrl.com_a == tpw_pkg::COM_TOGGLE
      |=> s_r.wave[0] != $past(s_r.wave[0]);
  endproperty
  a_pwm_toggle: assert property (p_pwm_toggle)
    else $error("PWM toggle missed");

  property p_off;
    ce_in && s_r.ctrl.com_a == tpw_pkg::COM_OFF
      |=> s_r.wave[0] == $past(s_r.wave[0]);
  endproperty
  a_off: assert property (p_off)
    else $error("wave moved with output off");

  c_pwm_top: cover property (ce_in && pwm && top_hit);
  c_ctc_top: cover property (ce_in && clear_on_match_mode && top_hit);
  c_ovf:     cover property (ce_in && ovf_set);
  c_hold:    cover property (!ce_in && tick_in);
  c_toggle:  cover property (ce_in && cmp_hit[0]
                             && s_r.ctrl.com_a == tpw_pkg::COM_TOGGLE);

endmodule // tpw_timer

// [tb/tpw_cpu.sv]
`timescale 1ns/1ps
module tpw_cpu (
  input  wire logic        clk_sys_in, // System clock
  input  wire logic [15:0] rdata_in,   // Read data
  output logic      [2:0]  addr_out,   // Register index
  output logic      [15:0] wdata_out,  // Write data
  output logic             wr_out,     // Write strobe
  output logic             rd_out,     // Read strobe
  output logic             tick_out,   // Timer clock enable
  output logic             ack_out     // Overflow serviced
);
  initial begin
    addr_out = 3'h0;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
    tick_out = 1'b0;
    ack_out = 1'b0;
  end
  // Released lines show the inverse, never the old value
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_sys_in);
    addr_out <= ~a;
    wdata_out <= ~d;
    wr_out <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    addr_out <= ~a;
    rd_out <= 1'b0;
    @(posedge clk_sys_in);
    d = rdata_in;
  endtask
  task automatic tick(input int n);
    tick_out <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    tick_out <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic ack();
    ack_out <= 1'b1;
    @(posedge clk_sys_in);
    ack_out <= 1'b0;
    @(posedge clk_sys_in);
  endtask
endmodule // tpw_cpu

// [tb/tpw_timer_test.sv]
`timescale 1ns/1ps
module tpw_timer_test;
  logic        clk_sys;
  logic        rst;
  logic        ce;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic        tick;
  logic        ack;
  logic [15:0] rdata;
  logic [1:0]  pin;
  logic [1:0]  oe_n;
  int          error_cnt = 0;
  int          checked = 0;

  tpw_timer i_dut (
    .clk_sys_in   (clk_sys),
    .rst_in       (rst),
    .ce_in        (ce),
    .tick_in      (tick),
    .ovf_ack_in   (ack),
    .addr_in      (addr),
    .wdata_in     (wdata),
    .wr_in        (wr),
    .rd_in        (rd),
    .rdata_out    (rdata),
    .wave_pin_out (pin),
    .wave_oe_n_out(oe_n)
  );
  tpw_cpu i_cpu (
    .clk_sys_in(clk_sys),
    .rdata_in  (rdata),
    .addr_out  (addr),
    .wdata_out (wdata),
    .wr_out    (wr),
    .rd_out    (rd),
    .tick_out  (tick),
    .ack_out   (ack)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] v;
    i_cpu.rd(a, v);
    chk(v, exp);
  endtask
  task automatic pinchk(input logic [3:0] exp);
    @(posedge clk_sys);
    chk({12'h000, oe_n, pin}, {12'h000, exp});
  endtask
  // Mode, channel A output mode, pin A output, flags cleared
  task automatic ctl(input logic [3:0] m, input logic [1:0] c);
    i_cpu.wr(tpw_pkg::ADDR_CTRL, {6'h00, 2'b01, 2'b00, c, m});
    i_cpu.wr(tpw_pkg::ADDR_FLAGS, 16'h000F);
  endtask

  task automatic t_normal();
    ctl(tpw_pkg::MODE_NORMAL, tpw_pkg::COM_OFF);
    i_cpu.wr(tpw_pkg::ADDR_COUNT, 16'hFFFE);
    i_cpu.tick(2);
    rdchk(tpw_pkg::ADDR_COUNT, 16'h0000);
    rdchk(tpw_pkg::ADDR_FLAGS, 16'h0001);
    pinchk(4'h8);
    i_cpu.ack();
    rdchk(tpw_pkg::ADDR_FLAGS, 16'h0000);
    $display("Test normal done");
  endtask

  // Enable low: writes and ticks both ignored
  task automatic t_hold();
    i_cpu.wr(tpw_pkg::ADDR_COUNT, 16'h0010);
    ce <= 1'b0;
    i_cpu.wr(tpw_pkg::ADDR_COUNT, 16'h0020);
    i_cpu.tick(3);
    ce <= 1'b1;
    rdchk(tpw_pkg::ADDR_COUNT, 16'h0010);
    $display("Test hold done");
  endtask

  task automatic t_ctc();
    ctl(tpw_pkg::MODE_CTC_OCR, tpw_pkg::COM_TOGGLE);
    i_cpu.wr(tpw_pkg::ADDR_CMPA, 16'h0005);
    i_cpu.wr(tpw_pkg::ADDR_COUNT, 16'h0000);
    i_cpu.tick(6);
    rdchk(tpw_pkg::ADDR_COUNT, 16'h0000);
    rdchk(tpw_pkg::ADDR_FLAGS, 16'h0002);
    pinchk(4'h9);
    i_cpu.wr(tpw_pkg::ADDR_FLAGS, 16'h000F);
    i_cpu.wr(tpw_pkg::ADDR_COUNT, 16'hFFFD);
    i_cpu.tick(3);
    rdchk(tpw_pkg::ADDR_COUNT, 16'h0000);
    rdchk(tpw_pkg::ADDR_FLAGS, 16'h0001);
    $display("Test clear on match done");
  endtask

  task automatic t_pwm();
    for (int c = 2; c < 4; c++) begin
      ctl(tpw_pkg::MODE_FPWM8, 2'(c));
      i_cpu.wr(tpw_pkg::ADDR_CMPA, 16'h1234);
      rdchk(tpw_pkg::ADDR_CMPA, 16'h0034);
      i_cpu.wr(tpw_pkg::ADDR_COUNT, 16'h00FE);
      i_cpu.tick(2);
      rdchk(tpw_pkg::ADDR_COUNT, 16'h0000);
      pinchk({3'b100, c == 2});
      i_cpu.tick(16'h35);
      pinchk({3'b100, c == 3});
      rdchk(tpw_pkg::ADDR_FLAGS, 16'h0007);
    end
    $display("Test fixed top pwm done");
  endtask

  task automatic t_icr();
    ctl(tpw_pkg::MODE_FPWM_ICR, tpw_pkg::COM_OFF);
    i_cpu.wr(tpw_pkg::ADDR_CAPT, 16'h0007);
    i_cpu.wr(tpw_pkg::ADDR_COUNT, 16'h0000);
    i_cpu.tick(8);
    rdchk(tpw_pkg::ADDR_FLAGS, 16'h0009);
    i_cpu.tick(6);
    i_cpu.wr(tpw_pkg::ADDR_CAPT, 16'h0003);
    i_cpu.tick(3);
    rdchk(tpw_pkg::ADDR_COUNT, 16'h0009);
    $display("Test capture top done");
  endtask

  task automatic t_buf();
    ctl(tpw_pkg::MODE_FPWM_OCR, tpw_pkg::COM_OFF);
    i_cpu.wr(tpw_pkg::ADDR_CMPA, 16'h0006);
    i_cpu.wr(tpw_pkg::ADDR_COUNT, 16'h0033);
    i_cpu.tick(2);
    rdchk(tpw_pkg::ADDR_COUNT, 16'h0000);
    rdchk(tpw_pkg::ADDR_FLAGS, 16'h0003);
    i_cpu.tick(7);
    rdchk(tpw_pkg::ADDR_COUNT, 16'h0000);
    ctl(tpw_pkg::MODE_FPWM_OCR, tpw_pkg::COM_TOGGLE);
    i_cpu.tick(7);
    pinchk(4'h8);
    i_cpu.tick(7);
    pinchk(4'h9);
    $display("Test buffered top done");
  endtask

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    repeat (19) @(posedge clk_sys);
    pinchk(4'hC);
    chk(rdata, 16'h0000);
    rst <= 1'b0;
    rdchk(tpw_pkg::ADDR_FLAGS, 16'h0000);
    $display("Test reset done");
    t_normal();
    t_hold();
    t_ctc();
    t_pwm();
    t_icr();
    t_buf();
    print_verdict();
  end
endmodule // tpw_timer_test
